// ---- bench/far_side_model.sv ----
// Purpose: far-side start sources, the timer gate and the timing generator
// Assumes: the bench commands the levels on its own clock
// Notes: levels change on the falling edge, out of phase with the sampler
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	input wire logic clk_i,
	input wire logic [3:0] gate_cmd_i,
	input wire logic [3:0] tgen_cmd_i,
	output logic [3:0] gate_o,
	output logic [3:0] timing_gen_o
);
	// --------
	// start sources
	// --------
	// launching on the falling edge keeps the levels asynchronous to the block
	always_ff @(negedge clk_i)
	begin
		gate_o <= gate_cmd_i;
		timing_gen_o <= tgen_cmd_i;
	end
endmodule // far_side_model
`default_nettype wire

// ---- bench/programmable_pulse_start_clock_reload_test.sv ----
// Purpose: self-checking bench of the pulse generator group
// Assumes: register map and bus timing of the hand-over contract
// Notes: phase lengths are counted in whole clocks at the falling edge
`timescale 1ns/1ps
`default_nettype none
module programmable_pulse_start_clock_reload_test;
	import pulse_gen_pkg::*;
	logic clk;
	logic rst_n;
	axil_req_type req;
	axil_rsp_type rsp;
	logic [3:0] gate_cmd;
	logic [3:0] tgen_cmd;
	logic [3:0] gate;
	logic [3:0] tgen;
	logic [3:0] pulse;
	logic [3:0] irq;
	logic [31:0] rd;
	logic [1:0] last_resp;
	int miscompares;
	int checks_done;
	// --------
	// design and far side
	// --------
	pulse_gen_group dut_u (
		.clk_i(clk),
		.rst_n_i(rst_n),
		.axil_req_i(req),
		.axil_rsp_o(rsp),
		.gate_i(gate),
		.timing_gen_i(tgen),
		.pulse_o(pulse),
		.irq_o(irq)
	);
	far_side_model far_u (
		.clk_i(clk),
		.gate_cmd_i(gate_cmd),
		.tgen_cmd_i(tgen_cmd),
		.gate_o(gate),
		.timing_gen_o(tgen)
	);
	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// --------
	// helpers
	// --------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
		end
	end
	endtask
	// one write; address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
	begin
		n = 0;
		@(posedge clk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			n++;
		end while (rsp.bvalid !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		req.bready <= 1'b0;
		last_resp = rsp.bresp;
	end
	endtask
	// one read; data and code are taken at the edge that shows rvalid
	task automatic axr(input logic [7:0] a);
		int n;
	begin
		n = 0;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			n++;
		end while (rsp.rvalid !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		req.rready <= 1'b0;
		rd = rsp.rdata;
		last_resp = rsp.rresp;
	end
	endtask
	task automatic wait_lvl(input int ch, input logic lvl);
		int n;
	begin
		n = 0;
		@(negedge clk);
		while (pulse[ch] !== lvl && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 20000) miscompares++;
	end
	endtask
	task automatic hold_len(input int ch, input logic lvl, output int n);
	begin
		n = 0;
		while (pulse[ch] === lvl && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
	end
	endtask
	task automatic phases(input int ch, output int hi, output int lo);
	begin
		wait_lvl(ch, 1'b1);
		hold_len(ch, 1'b1, hi);
		hold_len(ch, 1'b0, lo);
	end
	endtask
	// external levels need the two-flop sync before they count
	task automatic status_after();
	begin
		repeat (20) @(posedge clk);
		axr(STATUS_OFF);
	end
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_reset();
	begin
		axr(STATUS_OFF);
		check(rd, 32'h0);
		axr(8'h30);
		check(last_resp, RESP_SLVERR);
		axw(8'h30, 32'hFF);
		check(last_resp, RESP_SLVERR);
		$display("reset and map test done");
	end
	endtask
	task automatic t_div();
		int hi;
		int lo;
	begin
		axw(RELOAD_OFF, 32'h0);
		for (int c = 0; c < 4; c++)
		begin
			axw(CTRL_OFF, 32'(c));
			axw(START_OFF, 32'h1);
			phases(0, hi, lo);
			check(hi, 1 << (2 * c));
			check(lo, 1 << (2 * c));
			axw(START_OFF, 32'h0);
		end
		axw(CTRL_OFF, 32'h0);
		$display("divider test done");
	end
	endtask
	// new pair written mid-low: old high first, then both new widths
	task automatic t_buffer();
		int hi;
		int lo;
	begin
		axw(RELOAD_OFF, 32'h0105);
		axw(START_OFF, 32'h1);
		wait_lvl(0, 1'b1);
		wait_lvl(0, 1'b0);
		axw(RELOAD_OFF, 32'h0401);
		hold_len(0, 1'b0, lo);
		hold_len(0, 1'b1, hi);
		check(hi, 2);
		hold_len(0, 1'b0, lo);
		check(lo, 2);
		hold_len(0, 1'b1, hi);
		check(hi, 5);
		axw(START_OFF, 32'h0);
		$display("width buffer test done");
	end
	endtask
	task automatic t_flag();
	begin
		axw(RELOAD_OFF, 32'h001F);
		axw(START_OFF, 32'h1);
		wait_lvl(0, 1'b1);
		wait_lvl(0, 1'b0);
		axw(CTRL_OFF, 32'h0C);
		axw(CTRL_OFF, 32'h1C);
		wait_lvl(0, 1'b1);
		check(irq[0], 1'b0);
		wait_lvl(0, 1'b0);
		check(irq[0], 1'b1);
		axw(CTRL_OFF, 32'h14);
		check(irq[0], 1'b0);
		axr(CTRL_OFF);
		check(rd[FLAG_BIT], 1'b1);
		axw(CTRL_OFF, 32'h08);
		check(irq[0], 1'b0);
		wait_lvl(0, 1'b1);
		check(irq[0], 1'b1);
		axw(START_OFF, 32'h0);
		axw(CTRL_OFF, 32'h0);
		$display("underflow flag test done");
	end
	endtask
	task automatic t_stop();
	begin
		axw(RELOAD_OFF, 32'h3F00);
		axw(START_OFF, 32'h1);
		wait_lvl(0, 1'b1);
		axw(START_OFF, 32'h0);
		@(negedge clk);
		check(pulse[0], 1'b0);
		axr(STATUS_OFF);
		check(rd[7:4], 4'h0);
		$display("stop test done");
	end
	endtask
	task automatic t_wide();
		int hi;
		int lo;
	begin
		axw(CTRL_OFF, 32'h48);
		axw(CTRL_OFF + 8'h04, 32'h08);
		axw(RELOAD_OFF, 32'h0);
		axw(RELOAD_OFF + 8'h04, 32'h0001);
		axw(START_OFF, 32'h3);
		phases(0, hi, lo);
		check(hi, 1);
		check(lo, 257);
		wait_lvl(0, 1'b0);
		axw(CTRL_OFF, 32'h48);
		axw(CTRL_OFF + 8'h04, 32'h08);
		check(irq[1:0], 2'b00);
		wait_lvl(0, 1'b1);
		check(irq[1:0], 2'b11);
		axw(START_OFF, 32'h0);
		axw(CTRL_OFF, 32'h0);
		axw(CTRL_OFF + 8'h04, 32'h0);
		$display("joined counter test done");
	end
	endtask
	// output side keeps its own slowest divider, which must not matter
	task automatic t_chain();
		int hi;
		int lo;
	begin
		axw(CTRL_OFF, 32'h23);
		axw(RELOAD_OFF, 32'h0);
		axw(RELOAD_OFF + 8'h04, 32'h0101);
		axw(START_OFF, 32'h3);
		phases(0, hi, lo);
		check(hi, 2);
		check(lo, 2);
		axw(START_OFF, 32'h0);
		axw(CTRL_OFF, 32'h0);
		$display("chained test done");
	end
	endtask
	// joined pair 2/3 is the prescaler of joined pair 0/1, two clocks a phase
	task automatic t_quad();
		int hi;
		int lo;
	begin
		axw(CTRL_OFF, 32'h60);
		axw(CTRL_OFF + 8'h08, 32'h68);
		axw(CTRL_OFF + 8'h0C, 32'h08);
		axw(RELOAD_OFF, 32'h0001);
		axw(RELOAD_OFF + 8'h04, 32'h0);
		axw(RELOAD_OFF + 8'h08, 32'h0101);
		axw(RELOAD_OFF + 8'h0C, 32'h0);
		axw(START_OFF, 32'hF);
		phases(0, hi, lo);
		check(hi, 2);
		check(lo, 4);
		check(irq[3:2], 2'b11);
		axr(STATUS_OFF);
		check(rd[7:4], 4'hF);
		axw(START_OFF, 32'h0);
		@(negedge clk);
		check(pulse, 4'h0);
		axw(CTRL_OFF, 32'h0);
		axw(CTRL_OFF + 8'h08, 32'h0);
		axw(CTRL_OFF + 8'h0C, 32'h0);
		check(irq, 4'h0);
		$display("quad counter test done");
	end
	endtask
	task automatic t_start();
	begin
		axw(GATE_OFF, 32'h1);
		gate_cmd <= 4'h3;
		status_after();
		check(rd[7:4], 4'h1);
		axw(CTRL_OFF, 32'h80);
		status_after();
		check(rd[7:4], 4'h0);
		tgen_cmd <= 4'h3;
		status_after();
		check(rd[7:4], 4'h1);
		axw(CTRL_OFF, 32'hC0);
		status_after();
		check(rd[7:4], 4'h3);
		tgen_cmd <= 4'h0;
		status_after();
		check(rd[7:4], 4'h0);
		axw(CTRL_OFF, 32'h20);
		gate_cmd <= 4'hF;
		status_after();
		check(rd[7:4], 4'h0);
		gate_cmd <= 4'h0;
		axw(GATE_OFF, 32'h0);
		axw(CTRL_OFF, 32'h0);
		$display("start source test done");
	end
	endtask
	task automatic conclude();
	begin
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// --------
	// main sequence
	// --------
	initial
	begin
		miscompares = 0;
		checks_done = 0;
		req = '0;
		gate_cmd = 4'h0;
		tgen_cmd = 4'h0;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_div();
		t_buffer();
		t_flag();
		t_stop();
		t_wide();
		t_chain();
		t_quad();
		t_start();
		conclude();
	end
	// watchdog, about six times the expected run
	initial
	begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule // programmable_pulse_start_clock_reload_test
`default_nettype wire

// ---- logic/pulse_gen_group.sv ----
// Purpose: four-channel programmable pulse generator with AXI4-Lite
// Assumes: clk_i 50 MHz; gate and timing inputs are asynchronous
// Notes: 16-bit joins use the odd channel's reload as the high byte
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_group (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire pulse_gen_pkg::axil_req_type axil_req_i,
	output var pulse_gen_pkg::axil_rsp_type axil_rsp_o,
	input wire logic [3:0] gate_i,
	input wire logic [3:0] timing_gen_i,
	output logic [3:0] pulse_o,
	output logic [3:0] irq_o
);
	import pulse_gen_pkg::*;

	// -------------------------------------------------
	// reset and input synchronisers
	// -------------------------------------------------
	logic rst_s1;
	logic rst_n;
	logic [3:0] gate_s1;
	logic [3:0] gate_s;
	logic [3:0] tgen_s1;
	logic [3:0] tgen_s;

	// reset release passes two flops
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// start pins come from other clocks
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gate_s1 <= 4'h0;
			gate_s <= 4'h0;
			tgen_s1 <= 4'h0;
			tgen_s <= 4'h0;
		end
		else
		begin
			gate_s1 <= gate_i;
			gate_s <= gate_s1;
			tgen_s1 <= timing_gen_i;
			tgen_s <= tgen_s1;
		end
	end

	// -------------------------------------------------
	// register slave
	// -------------------------------------------------
	logic aw_full;
	logic w_full;
	logic [7:0] waddr;
	logic [31:0] wdat;
	logic [3:0] wstb;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic [31:0] rd_mux;
	logic rd_ok;
	logic wr_go;
	logic wr_ok;
	logic [1:0] widx;

	logic [3:0][1:0] clk_div_sel;
	logic [3:0] flag_timing_select;
	logic [3:0] underflow_irq_enable;
	logic [3:0] underflow_flag;
	logic [3:0][7:0] low_width_reload;
	logic [3:0][7:0] high_width_reload;
	logic [3:0] chan_start_bit;
	logic [1:0][1:0] pair_mode_field;
	logic [1:0] timing_gen_sel;
	logic [1:0] gate_start_sel;
	logic [3:0] pulse;
	logic [3:0] running;
	logic [3:0] uf_set;

	assign axil_rsp_o.awready = !aw_full && !bvalid;
	assign axil_rsp_o.wready = !w_full && !bvalid;
	assign axil_rsp_o.bvalid = bvalid;
	assign axil_rsp_o.bresp = bresp;
	assign axil_rsp_o.arready = !rvalid;
	assign axil_rsp_o.rvalid = rvalid;
	assign axil_rsp_o.rdata = rdata;
	assign axil_rsp_o.rresp = rresp;
	assign wr_go = aw_full && w_full && !bvalid;
	assign widx = waddr[3:2];
	// status is read-only but a write to it is harmless
	assign wr_ok = (waddr[7:5] == 3'h0) || (waddr == START_OFF)
		|| (waddr == GATE_OFF) || (waddr == STATUS_OFF);

	// address and data may arrive in either order
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			waddr <= 8'h00;
			wdat <= 32'h0000_0000;
			wstb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else
		begin
			if (axil_req_i.awvalid && axil_rsp_o.awready)
			begin
				aw_full <= 1'b1;
				waddr <= {axil_req_i.awaddr[7:2], 2'b00};
			end
			if (axil_req_i.wvalid && axil_rsp_o.wready)
			begin
				w_full <= 1'b1;
				wdat <= axil_req_i.wdata;
				wstb <= axil_req_i.wstrb;
			end
			if (wr_go)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid && axil_req_i.bready)
				bvalid <= 1'b0;
		end
	end

	// read data mux, unmapped words answer an error
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		if (axil_req_i.araddr[7:4] == CTRL_OFF[7:4])
		begin
			rd_mux[CSEL_LSB +: 2] = clk_div_sel[axil_req_i.araddr[3:2]];
			rd_mux[FTIM_BIT] = flag_timing_select[axil_req_i.araddr[3:2]];
			rd_mux[IE_BIT] = underflow_irq_enable[axil_req_i.araddr[3:2]];
			rd_mux[FLAG_BIT] = underflow_flag[axil_req_i.araddr[3:2]];
			if (!axil_req_i.araddr[2])
			begin
				rd_mux[MODE_LSB +: 2] = pair_mode_field[axil_req_i.araddr[3]];
				rd_mux[TSEL_BIT] = timing_gen_sel[axil_req_i.araddr[3]];
			end
		end
		else if (axil_req_i.araddr[7:4] == RELOAD_OFF[7:4])
		begin
			rd_mux[7:0] = low_width_reload[axil_req_i.araddr[3:2]];
			rd_mux[HI_LSB +: 8] = high_width_reload[axil_req_i.araddr[3:2]];
		end
		else if (axil_req_i.araddr[7:2] == START_OFF[7:2])
			rd_mux[3:0] = chan_start_bit;
		else if (axil_req_i.araddr[7:2] == GATE_OFF[7:2])
			rd_mux[1:0] = gate_start_sel;
		else if (axil_req_i.araddr[7:2] == STATUS_OFF[7:2])
			rd_mux[7:0] = {running, pulse};
		else
			rd_ok = 1'b0;
	end

	// read answers one cycle after the address is taken
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end
		else if (axil_req_i.arvalid && !rvalid)
		begin
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid && axil_req_i.rready)
			rvalid <= 1'b0;
	end

	// configuration writes; mode and timing select live on even words
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_div_sel <= '0;
			flag_timing_select <= 4'h0;
			underflow_irq_enable <= 4'h0;
			low_width_reload <= {4{RELOAD_RST}};
			high_width_reload <= {4{RELOAD_RST}};
			chan_start_bit <= 4'h0;
			pair_mode_field <= '0;
			timing_gen_sel <= 2'h0;
			gate_start_sel <= 2'h0;
		end
		else if (wr_go)
		begin
			if (waddr[7:4] == CTRL_OFF[7:4] && wstb[0])
			begin
				clk_div_sel[widx] <= wdat[CSEL_LSB +: 2];
				flag_timing_select[widx] <= wdat[FTIM_BIT];
				underflow_irq_enable[widx] <= wdat[IE_BIT];
				if (!widx[0])
				begin
					pair_mode_field[widx[1]] <= wdat[MODE_LSB +: 2];
					timing_gen_sel[widx[1]] <= wdat[TSEL_BIT];
				end
			end
			if (waddr[7:4] == RELOAD_OFF[7:4])
			begin
				// widths may change while running
				if (wstb[0])
					low_width_reload[widx] <= wdat[7:0];
				if (wstb[1])
					high_width_reload[widx] <= wdat[HI_LSB +: 8];
			end
			if (waddr == START_OFF && wstb[0])
				chan_start_bit <= wdat[3:0];
			if (waddr == GATE_OFF && wstb[0])
				gate_start_sel <= wdat[1:0];
		end
	end

	// flag: hardware set beats a same-cycle clearing write
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			underflow_flag <= 4'h0;
		else
			for (int i = 0; i < 4; i++)
			begin
				if (uf_set[i])
					underflow_flag[i] <= 1'b1;
				else if (wr_go && waddr[7:4] == CTRL_OFF[7:4]
					&& widx == i[1:0] && wstb[0] && !wdat[FLAG_BIT])
					underflow_flag[i] <= 1'b0;
			end
	end

	assign irq_o = underflow_flag & underflow_irq_enable;
	assign pulse_o = pulse;

	// -------------------------------------------------
	// pair modes and channel engines
	// -------------------------------------------------
	pair_mode_type pmode [2];
	logic quad;
	logic [3:0] pulse_d;
	logic [3:0] edge_seen;

	// 11 on both pairs is the quad; 11 alone falls back to 8-bit
	assign quad = pair_mode_field[0] == 2'b11
		&& pair_mode_field[1] == 2'b11;
	always_comb
	begin
		for (int p = 0; p < 2; p++)
		begin
			case (pair_mode_field[p])
				2'b00: pmode[p] = MODE_8;
				2'b01: pmode[p] = MODE_88;
				2'b10: pmode[p] = MODE_16;
				2'b11: pmode[p] = quad ? MODE_1616 : MODE_8;
				default: pmode[p] = MODE_8;
			endcase
		end
	end

	// previous output levels, for both-edge counting
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			pulse_d <= 4'h0;
		else
			pulse_d <= pulse;
	end
	assign edge_seen = pulse ^ pulse_d;

	for (genvar c = 0; c < 4; c++)
	begin : g_ch
		localparam int B = c - (c % 2);
		localparam int SP = (c % 2 == 0) ? c + 1 : c;
		localparam int P = c / 2;
		logic joined;
		logic outside;
		logic start;
		logic tick;
		logic [1:0] sel;
		logic [5:0] lim;
		logic [5:0] pre;
		logic [15:0] cnt;
		logic [15:0] hbuf;
		logic [15:0] lo_w;
		logic [15:0] hi_w;

		assign joined = pmode[P] == MODE_16 || pmode[P] == MODE_1616;
		assign outside = (pmode[P] == MODE_88 && c % 2 == 0)
			|| (pmode[P] == MODE_1616 && c < 2);
		// joined pairs run on the even divider so both stay in step
		assign sel = joined ? clk_div_sel[B] : clk_div_sel[c];
		assign lo_w = joined
			? {low_width_reload[B+1], low_width_reload[B]}
			: {8'h00, low_width_reload[c]};
		assign hi_w = joined
			? {high_width_reload[B+1], high_width_reload[B]}
			: {8'h00, high_width_reload[c]};

		// divider terminal count
		always_comb
		begin
			case (sel)
				2'b00: lim = DIV1_LAST;
				2'b01: lim = DIV4_LAST;
				2'b10: lim = DIV16_LAST;
				2'b11: lim = DIV64_LAST;
				default: lim = DIV1_LAST;
			endcase
		end

		// output side ignores its divider
		assign tick = outside
			? (pmode[P] == MODE_1616 ? edge_seen[2] : edge_seen[SP])
			: (pre == lim);

		// start source; chained modes take the start bit only
		always_comb
		begin
			start = chan_start_bit[c];
			if (pmode[P] == MODE_8 || pmode[P] == MODE_16)
			begin
				if (pmode[P] == MODE_16 || c % 2 == 0)
				begin
					if (timing_gen_sel[P])
						start = tgen_s[c];
					else if (gate_start_sel[P])
						start = gate_s[c];
				end
			end
		end

		// underflow ends a phase; flag per timing select
		assign uf_set[c] = running[c] && start && tick && cnt == 16'h0000
			&& (!flag_timing_select[c] || pulse[c]);

		// phase counter: low from reload, high from buffer
		always_ff @(posedge clk_i or negedge rst_n)
		begin
			if (!rst_n)
			begin
				running[c] <= 1'b0;
				pulse[c] <= 1'b0;
				pre <= 6'h00;
				cnt <= 16'h0000;
				hbuf <= 16'h0000;
			end
			else
			begin
				running[c] <= start;
				if (!start)
				begin
					pulse[c] <= 1'b0;
					pre <= 6'h00;
				end
				else if (!running[c])
				begin
					pulse[c] <= 1'b0;
					pre <= 6'h00;
					cnt <= lo_w;
					hbuf <= hi_w;
				end
				else
				begin
					pre <= (pre == lim) ? 6'h00 : pre + 6'h01;
					if (tick && cnt == 16'h0000)
					begin
						pulse[c] <= !pulse[c];
						cnt <= pulse[c] ? lo_w : hbuf;
						if (pulse[c])
							hbuf <= hi_w;
					end
					else if (tick)
						cnt <= cnt - 16'h0001;
				end
			end
		end
	end

	// -------------------------------------------------
	// assertions on channel 0 and pair 0
	// -------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	// judged on the selected start, so external starts cannot trip it
	property p_stop_low;
		!g_ch[0].start |=> !pulse_o[0];
	endproperty
	a_stop_low: assert property (p_stop_low)
		else $error("output not low after stop");

	property p_flag_set;
		uf_set[0] |=> underflow_flag[0] && irq_o[0] == underflow_irq_enable[0];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag not set on underflow");

	// a clear flag stays clear across the end of a low phase
	property p_high_only;
		flag_timing_select[0] && !underflow_flag[0] && !pulse_o[0]
			|=> !underflow_flag[0];
	endproperty
	a_high_only: assert property (p_high_only)
		else $error("flag set at end of low phase");

	property p_joined_flags;
		pmode[0] == MODE_16 && uf_set[0] && chan_start_bit[1:0] == 2'b11
			&& $past(chan_start_bit[1:0]) == 2'b11 |-> uf_set[1];
	endproperty
	a_joined_flags: assert property (p_joined_flags)
		else $error("joined flags not set together");

	property p_div4;
		g_ch[0].sel == 2'b01 && g_ch[0].tick && !g_ch[0].outside
			&& running[0] && g_ch[0].start
			##1 g_ch[0].sel == 2'b01 |-> !g_ch[0].tick [*3];
	endproperty
	a_div4: assert property (p_div4)
		else $error("divide by four ticks too early");

	property p_load_low;
		running[0] && g_ch[0].start && g_ch[0].tick
			&& g_ch[0].cnt == 16'h0000 && pulse[0]
			|=> g_ch[0].cnt == $past(g_ch[0].lo_w) && !pulse[0];
	endproperty
	a_load_low: assert property (p_load_low)
		else $error("low width not loaded");

	property p_reg_only;
		pmode[0] == MODE_88 |-> g_ch[0].start == chan_start_bit[0];
	endproperty
	a_reg_only: assert property (p_reg_only)
		else $error("chained mode took external start");

	property p_odd_own;
		pmode[0] == MODE_8 |-> g_ch[1].start == chan_start_bit[1];
	endproperty
	a_odd_own: assert property (p_odd_own)
		else $error("odd channel took external start");

	property p_irq;
		underflow_flag[0] && underflow_irq_enable[0] |-> irq_o[0];
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing");

	c_flag: cover property (uf_set[0] && underflow_irq_enable[0]);
	c_chain: cover property (pmode[0] == MODE_88 && g_ch[0].tick);
	c_join: cover property (pmode[0] == MODE_16 && uf_set[1]);
	c_quad: cover property (pmode[0] == MODE_1616 && g_ch[0].tick);
endmodule // pulse_gen_group
`default_nettype wire

// ---- logic/pulse_gen_pkg.sv ----
// Purpose: shared constants and types of the pulse generator group
// Assumes: AXI4-Lite slave with 8-bit byte addresses, 32-bit data
// Notes: four channels, two pairs, one optional 16+16 quad
`default_nettype none
package pulse_gen_pkg;
	// -------------------------------------------------
	// bus carriers
	// -------------------------------------------------
	typedef struct packed {
		logic [7:0] awaddr;
		logic [2:0] awprot;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic [2:0] arprot;
		logic arvalid;
		logic rready;
	} axil_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_type;
	// -------------------------------------------------
	// register map and fields
	// -------------------------------------------------
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] RELOAD_OFF = 8'h10;
	localparam logic [7:0] START_OFF = 8'h20;
	localparam logic [7:0] GATE_OFF = 8'h24;
	localparam logic [7:0] STATUS_OFF = 8'h28;
	localparam int CSEL_LSB = 0;
	localparam int FTIM_BIT = 2;
	localparam int IE_BIT = 3;
	localparam int FLAG_BIT = 4;
	localparam int MODE_LSB = 5;
	localparam int TSEL_BIT = 7;
	localparam int HI_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	// prescaler terminal counts: 1, 4, 16, 64 clocks per count
	localparam logic [5:0] DIV1_LAST = 6'h00;
	localparam logic [5:0] DIV4_LAST = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;
	typedef enum logic [1:0] {
		MODE_8 = 2'b00,
		MODE_88 = 2'b01,
		MODE_16 = 2'b10,
		MODE_1616 = 2'b11
	} pair_mode_type;
endpackage
`default_nettype wire
